// *** rtl/imust_core.sv ***
// file: gyroscope and accelerometer self-test control core
// ==========================================
// Notes on behaviour
// - while accel self-test is on, a static offset of chosen sign is added to the acceleration.
// - the gyro self-test runs a drive test, a sense test and a datapath test in turn.
// - the done flag rises when the triggered test ends and holds until the next trigger.
// - the trigger status reports success or which part of the test failed.
// - one ok flag per axis is set when that axis passes every part.
// - a drive test runs by itself on a gyro start-up that comes while no test is running, per the enable and fast power-up edges.
// - a failed start-up drive test sets the fatal flag within 320 ms of its start.
`timescale 1ns/1ps
`default_nettype none
module imust_core #(
  parameter int unsigned DRIVE_CYCLES = imust_pkg::DRIVE_TEST_CYCLES_DEF,
  parameter int unsigned SENSE_CYCLES = imust_pkg::SENSE_TEST_CYCLES_DEF,
  parameter int unsigned PATH_CYCLES = imust_pkg::PATH_TEST_CYCLES_DEF,
  parameter int unsigned FATAL_CYCLES = imust_pkg::FATAL_LIMIT_CYCLES
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  // accelerometer path
  input wire logic acc_test_en_in,
  input wire logic acc_test_positive_in,
  input wire logic [15:0] acc_x_in,
  input wire logic [15:0] acc_y_in,
  input wire logic [15:0] acc_z_in,
  output logic [15:0] acc_x_out,
  output logic [15:0] acc_y_out,
  output logic [15:0] acc_z_out,
  // gyroscope control
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_in,
  input wire logic gyro_enable_in,
  input wire logic fast_powerup_in,
  // per-axis results of the analog checks, sampled when each part ends
  input wire logic [2:0] drive_ok_in,
  input wire logic [2:0] sense_ok_in,
  input wire logic [2:0] path_ok_in,
  output logic busy_out,
  output logic gyro_test_done_out,
  output logic [2:0] trig_status_out,
  output logic [2:0] axis_ok_out,
  output logic fatal_err_out
);
  // elaboration checks: a zero-length part would wrap the timer load value,
  // and the start-up drive test must end inside the fatal reporting limit
  if (DRIVE_CYCLES < 1 || SENSE_CYCLES < 1 || PATH_CYCLES < 1) begin : g_len_check
    $error("test length below 1");
  end
  if (DRIVE_CYCLES > FATAL_CYCLES) begin : g_fatal_check
    $error("drive test longer than fatal limit");
  end

  // ==========================================
  // accelerometer offset injection
  wire logic [15:0] st_off = acc_test_positive_in ? imust_pkg::ACC_ST_OFFSET
                                                  : 16'(-imust_pkg::ACC_ST_OFFSET);
  wire logic [15:0] add_off = acc_test_en_in ? st_off : 16'h0000;
  // registered outputs; the offset superposes on whatever the sensor reports
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_x_out <= 16'h0000;
      acc_y_out <= 16'h0000;
      acc_z_out <= 16'h0000;
    end else begin
      acc_x_out <= acc_x_in + add_off;
      acc_y_out <= acc_y_in + add_off;
      acc_z_out <= acc_z_in + add_off;
    end
  end

  // ==========================================
  // start-up and trigger detection
  logic gyro_en_q;
  logic fup_q;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gyro_en_q <= 1'b0;
      fup_q <= 1'b0;
    end else begin
      gyro_en_q <= gyro_enable_in;
      fup_q <= fast_powerup_in;
    end
  end
  wire logic startup = (gyro_enable_in && !gyro_en_q && !fast_powerup_in)
                    || (fast_powerup_in && !fup_q && !gyro_enable_in);
  imust_pkg::imust_state_t state;
  imust_pkg::imust_state_t next_state;
  logic manual;
  wire logic trigger = cmd_valid_in && (cmd_in == imust_pkg::CMD_GYRO_TRIGGER);
  // triggers are refused while a test is running
  wire logic accept = trigger && (state == imust_pkg::IMUST_IDLE || state == imust_pkg::IMUST_DONE);
  wire logic auto_start = startup && !accept
                       && (state == imust_pkg::IMUST_IDLE || state == imust_pkg::IMUST_DONE);

  // ==========================================
  // phase timer
  logic tmr_start;
  logic [31:0] tmr_load;
  logic tmr_exp;
  imust_timer #(.WIDTH(32)) u_phase (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .start_in(tmr_start),
    .load_in(tmr_load),
    .stop_in(1'b0),
    .running_out(),
    .expired_out(tmr_exp)
  );
  wire logic drive_bad = drive_ok_in != 3'b111;
  wire logic sense_bad = sense_ok_in != 3'b111;
  wire logic path_bad = path_ok_in != 3'b111;
  // the three parts run back to back, each for its own count
  always_comb begin
    next_state = state;
    tmr_start = 1'b0;
    tmr_load = 32'(DRIVE_CYCLES - 1);
    case (state)
      imust_pkg::IMUST_IDLE, imust_pkg::IMUST_DONE: begin
        if (accept || auto_start) begin
          next_state = imust_pkg::IMUST_DRIVE;
          tmr_start = 1'b1;
        end
      end
      imust_pkg::IMUST_DRIVE: begin
        if (tmr_exp) begin
          if (!manual) begin
            next_state = imust_pkg::IMUST_IDLE; // drive test only on start-up
          end else begin
            next_state = imust_pkg::IMUST_SENSE;
            tmr_start = 1'b1;
            tmr_load = 32'(SENSE_CYCLES - 1);
          end
        end
      end
      imust_pkg::IMUST_SENSE: begin
        if (tmr_exp) begin
          next_state = imust_pkg::IMUST_PATH;
          tmr_start = 1'b1;
          tmr_load = 32'(PATH_CYCLES - 1);
        end
      end
      imust_pkg::IMUST_PATH: begin
        if (tmr_exp) begin
          next_state = imust_pkg::IMUST_DONE;
        end
      end
      default: next_state = imust_pkg::IMUST_IDLE;
    endcase
  end

  // ==========================================
  // state, results and flags
  logic [2:0] axis_acc;
  logic [2:0] first_err;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= imust_pkg::IMUST_IDLE;
      manual <= 1'b0;
      axis_acc <= 3'b000;
      first_err <= imust_pkg::TRIG_STATUS_IDLE;
      gyro_test_done_out <= 1'b0;
      trig_status_out <= imust_pkg::TRIG_STATUS_IDLE;
      axis_ok_out <= 3'b000;
      fatal_err_out <= 1'b0;
    end else begin
      state <= next_state;
      if (accept) begin
        manual <= 1'b1;
        axis_acc <= 3'b111;
        first_err <= imust_pkg::TRIG_STATUS_OK;
        gyro_test_done_out <= 1'b0;
        axis_ok_out <= 3'b000;
        trig_status_out <= imust_pkg::TRIG_STATUS_IDLE;
      end else if (auto_start) begin
        manual <= 1'b0;
      end
      if (state == imust_pkg::IMUST_DRIVE && tmr_exp) begin
        axis_acc <= axis_acc & drive_ok_in;
        if (manual && drive_bad) first_err <= imust_pkg::TRIG_STATUS_DRIVE_ERR;
        if (drive_bad) fatal_err_out <= 1'b1;
      end
      if (state == imust_pkg::IMUST_SENSE && tmr_exp) begin
        axis_acc <= axis_acc & sense_ok_in;
        if (sense_bad && first_err == imust_pkg::TRIG_STATUS_OK) begin
          first_err <= imust_pkg::TRIG_STATUS_SENSE_ERR;
        end
      end
      if (state == imust_pkg::IMUST_PATH && tmr_exp) begin
        gyro_test_done_out <= 1'b1;
        axis_ok_out <= axis_acc & path_ok_in;
        trig_status_out <= (path_bad && first_err == imust_pkg::TRIG_STATUS_OK)
                         ? imust_pkg::TRIG_STATUS_PATH_ERR : first_err;
      end
    end
  end
  assign busy_out = state != imust_pkg::IMUST_IDLE && state != imust_pkg::IMUST_DONE;

  // ==========================================
  // checks
  property p_offset;
    @(posedge clock_in) disable iff (!resetn_in)
      acc_test_en_in |=> acc_x_out == 16'($past(acc_x_in) + ($past(acc_test_positive_in)
        ? imust_pkg::ACC_ST_OFFSET : 16'(-imust_pkg::ACC_ST_OFFSET)));
  endproperty
  a_offset: assert property (p_offset) else $error("offset missing");
  property p_seq;
    @(posedge clock_in) disable iff (!resetn_in)
      (state == imust_pkg::IMUST_DRIVE && tmr_exp && manual) |=> state == imust_pkg::IMUST_SENSE;
  endproperty
  a_seq: assert property (p_seq) else $error("sense part skipped");
  property p_done;
    @(posedge clock_in) disable iff (!resetn_in)
      (state == imust_pkg::IMUST_PATH && tmr_exp) |=> gyro_test_done_out;
  endproperty
  a_done: assert property (p_done) else $error("done not set");
  property p_status;
    @(posedge clock_in) disable iff (!resetn_in)
      $rose(gyro_test_done_out) |-> trig_status_out != imust_pkg::TRIG_STATUS_IDLE;
  endproperty
  a_status: assert property (p_status) else $error("no status at done");
  property p_axes;
    @(posedge clock_in) disable iff (!resetn_in)
      (axis_ok_out != 3'b000) |-> gyro_test_done_out;
  endproperty
  a_axes: assert property (p_axes) else $error("axis ok without done");
  property p_startup;
    @(posedge clock_in) disable iff (!resetn_in)
      (startup && state == imust_pkg::IMUST_IDLE && !trigger) |=> state == imust_pkg::IMUST_DRIVE;
  endproperty
  a_startup: assert property (p_startup) else $error("start-up drive test missing");
  property p_fatal;
    @(posedge clock_in) disable iff (!resetn_in)
      (state == imust_pkg::IMUST_DRIVE && tmr_exp && drive_bad) |=> fatal_err_out;
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal not flagged");
  property p_clear;
    @(posedge clock_in) disable iff (!resetn_in)
      accept |=> !gyro_test_done_out && axis_ok_out == 3'b000;
  endproperty
  a_clear: assert property (p_clear) else $error("stale results");
endmodule
`default_nettype wire

// *** rtl/imust_pkg.sv ***
// package: constants for the imu self-test controller
package imust_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FATAL_LIMIT_MS = 320;
  localparam int unsigned FATAL_LIMIT_CYCLES = FATAL_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned DRIVE_TEST_CYCLES_DEF = 1000;
  localparam int unsigned SENSE_TEST_CYCLES_DEF = 1000;
  localparam int unsigned PATH_TEST_CYCLES_DEF = 1000;
  // static offset added to acceleration during self-test (arbitrary plain default)
  localparam logic [15:0] ACC_ST_OFFSET = 16'h0800;
  // trigger status codes
  localparam logic [2:0] TRIG_STATUS_IDLE = 3'h0;
  localparam logic [2:0] TRIG_STATUS_OK = 3'h1;
  localparam logic [2:0] TRIG_STATUS_DRIVE_ERR = 3'h2;
  localparam logic [2:0] TRIG_STATUS_SENSE_ERR = 3'h3;
  localparam logic [2:0] TRIG_STATUS_PATH_ERR = 3'h4;
  localparam logic [2:0] TRIG_STATUS_ABORT = 3'h5;
  // command opcode for the gyroscope trigger
  localparam logic [7:0] CMD_GYRO_TRIGGER = 8'h02;
  localparam int unsigned AXES = 3;
  typedef enum logic [2:0] {
    IMUST_IDLE = 3'b000,
    IMUST_DRIVE = 3'b001,
    IMUST_SENSE = 3'b010,
    IMUST_PATH = 3'b011,
    IMUST_DONE = 3'b100
  } imust_state_t;
endpackage

// *** rtl/imust_timer.sv ***
// file: down-counting timer with a start pulse and a one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module imust_timer #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic [WIDTH-1:0] load_in,
  input wire logic stop_in,
  output logic running_out,
  output logic expired_out
);
  logic [WIDTH-1:0] count;
  logic running;
  wire logic last = running && (count == '0);
  // a zero-width counter cannot hold any load value
  if (WIDTH < 1) begin : g_width_check
    $error("timer width below 1");
  end
  // ==========================================
  // countdown
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= '0;
      running <= 1'b0;
    end else if (start_in) begin
      count <= load_in;
      running <= 1'b1;
    end else if (stop_in || last) begin
      running <= 1'b0;
    end else if (running) begin
      count <= count - WIDTH'(1);
    end
  end
  assign running_out = running;
  assign expired_out = last;
endmodule
`default_nettype wire

// *** bench/imust_host_model.sv ***
// host side model: issues opcodes on the command port
`timescale 1ns/1ps
`default_nettype none
module imust_host_model (
  input wire logic clock_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_out
);
  // ==========================================
  // command write
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = 8'h00;
  end
  // one-cycle write; released data is inverted so a stale opcode never looks valid
  task automatic send(input logic [7:0] op);
    @(negedge clock_in);
    cmd_valid_out = 1'b1;
    cmd_out = op;
    @(negedge clock_in);
    cmd_valid_out = 1'b0;
    cmd_out = ~op;
  endtask
endmodule
`default_nettype wire

// *** bench/imu_sensor_self_test_test.sv ***
// testbench for the imu self-test controller
`timescale 1ns/1ps
`default_nettype none
module imu_sensor_self_test_test;
  // ==========================================
  // short counts keep the run brief
  localparam int unsigned N = 4;
  localparam int unsigned FATAL = 8;
  // cycles from the accepting edge to the edge that raises done
  localparam int unsigned TOTAL = 3 * N;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic acc_en = 1'b0, acc_pos = 1'b0, gyro_en = 1'b0, fup = 1'b0;
  logic [15:0] ax = 16'h0000, ay = 16'h0000, az = 16'h0000, ox, oy, oz;
  logic [2:0] d_ok = 3'h7, s_ok = 3'h7, p_ok = 3'h7, status, axis;
  logic cmd_valid, busy, done, fatal;
  logic [7:0] cmd;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #5 clock_in = ~clock_in;
  imust_host_model host_u (.clock_in(clock_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd));
  imust_core #(.DRIVE_CYCLES(N), .SENSE_CYCLES(N), .PATH_CYCLES(N), .FATAL_CYCLES(FATAL)) dut_u (
    .clock_in(clock_in), .resetn_in(resetn_in), .acc_test_en_in(acc_en),
    .acc_test_positive_in(acc_pos), .acc_x_in(ax), .acc_y_in(ay), .acc_z_in(az),
    .acc_x_out(ox), .acc_y_out(oy), .acc_z_out(oz), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .gyro_enable_in(gyro_en), .fast_powerup_in(fup), .drive_ok_in(d_ok), .sense_ok_in(s_ok),
    .path_ok_in(p_ok), .busy_out(busy), .gyro_test_done_out(done), .trig_status_out(status),
    .axis_ok_out(axis), .fatal_err_out(fatal));
  // ==========================================
  // shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch and ends the run
  always @(posedge clock_in) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic do_reset();
    @(negedge clock_in);
    resetn_in = 1'b0;
    repeat (3) @(negedge clock_in);
    resetn_in = 1'b1;
    check({busy, done, status, axis, fatal}, 16'h0000, "outputs after reset");
  endtask
  // one triggered test; a second trigger while busy must be ignored
  task automatic run_trig(input logic [2:0] d, s, p, st);
    d_ok = d;
    s_ok = s;
    p_ok = p;
    host_u.send(imust_pkg::CMD_GYRO_TRIGGER);
    check(busy, 1'b1, "busy after trigger");
    check({done, axis, status}, 16'h0000, "stale results cleared");
    host_u.send(imust_pkg::CMD_GYRO_TRIGGER);
    repeat (TOTAL - 3) @(negedge clock_in);
    check(done, 1'b0, "done early");
    @(negedge clock_in);
    check(done, 1'b1, "done on time");
    check(status, st, "trigger status");
    check(axis, d & s & p, "axis ok flags");
  endtask
  // ==========================================
  // main sequence
  initial begin
    do_reset();
    // settle pause before self-test, scaled down from the real wait
    repeat (2) @(negedge clock_in);
    // accel offset in both polarities and off
    ax = 16'h1234;
    ay = 16'h0100;
    az = 16'hff00;
    acc_en = 1'b1;
    acc_pos = 1'b1;
    @(negedge clock_in);
    @(negedge clock_in);
    check(ox, ax + imust_pkg::ACC_ST_OFFSET, "positive offset x");
    check(oy, ay + imust_pkg::ACC_ST_OFFSET, "positive offset y");
    acc_pos = 1'b0;
    @(negedge clock_in);
    @(negedge clock_in);
    check(oz, az - imust_pkg::ACC_ST_OFFSET, "negative offset z");
    check(oy, ay - imust_pkg::ACC_ST_OFFSET, "negative offset y");
    acc_en = 1'b0;
    @(negedge clock_in);
    @(negedge clock_in);
    check(ox, ax, "offset removed");
    $display("test accel offset done");
    // wrong opcode is ignored
    host_u.send(~imust_pkg::CMD_GYRO_TRIGGER);
    check(busy, 1'b0, "foreign opcode");
    // ok code and each of the three failure codes, back to back
    run_trig(3'h7, 3'h7, 3'h7, imust_pkg::TRIG_STATUS_OK);
    run_trig(3'h6, 3'h7, 3'h7, imust_pkg::TRIG_STATUS_DRIVE_ERR);
    run_trig(3'h7, 3'h5, 3'h7, imust_pkg::TRIG_STATUS_SENSE_ERR);
    run_trig(3'h7, 3'h7, 3'h3, imust_pkg::TRIG_STATUS_PATH_ERR);
    $display("test gyro trigger done");
    // start-up by fast power-up with gyro off: drive test passes
    do_reset();
    d_ok = 3'h7;
    fup = 1'b1;
    @(negedge clock_in);
    @(negedge clock_in);
    check(busy, 1'b1, "start-up by fast power-up");
    repeat (N + 2) @(negedge clock_in);
    check({fatal, done, status}, 16'h0000, "passing start-up");
    // gyro enable while fast power-up is set is no start-up
    gyro_en = 1'b1;
    @(negedge clock_in);
    @(negedge clock_in);
    check(busy, 1'b0, "enable with fast power-up");
    gyro_en = 1'b0;
    fup = 1'b0;
    @(negedge clock_in);
    // start-up by gyro enable with a failing drive test
    d_ok = 3'h5;
    gyro_en = 1'b1;
    @(negedge clock_in);
    @(negedge clock_in);
    check(busy, 1'b1, "start-up by enable");
    for (int i = 0; i < FATAL && fatal !== 1'b1; i++) @(negedge clock_in);
    check(fatal, 1'b1, "fatal after failed drive");
    run_trig(3'h7, 3'h7, 3'h7, imust_pkg::TRIG_STATUS_OK);
    check(fatal, 1'b1, "fatal sticky");
    gyro_en = 1'b0;
    do_reset();
    $display("test start-up done");
    give_verdict();
  end
endmodule
`default_nettype wire
